// >>> hdl/pldsup_csum.sv
`timescale 1ns/100ps
`include "pldsup_regs.svh"
// ==========================================
// checksum over array and signature
module pldsup_csum #(
    parameter int CFG_W = `PLDSUP_CFG_BITS,
    parameter int SIG_W = `PLDSUP_SIG_BITS
) (
    input  wire logic [CFG_W-1:0] cfg,
    input  wire logic [SIG_W-1:0] sig,
    output logic      [15:0]      csum
);
    function automatic logic [15:0] fold16(input logic [15:0] acc, input logic [15:0] w);
        fold16 = acc + w;
    endfunction : fold16

    always_comb begin
        csum = `PLDSUP_CSUM_SEED;
        for (int i = 0; i < CFG_W / 16; i++) begin
            csum = fold16(csum, cfg[i*16 +: 16]);
        end
        for (int i = 0; i < SIG_W / 16; i++) begin
            csum = fold16({csum[14:0], csum[15]}, sig[i*16 +: 16]);
        end
    end
endmodule : pldsup_csum

// >>> hdl/pldsup_top.sv
`timescale 1ns/100ps
`include "pldsup_regs.svh"
// Behaviour
// - the device holds a 64-bit user signature that the programmer can rewrite.
// - the signature can be read back whether or not the lock cell is set.
// - the checksum covers the signature, so a changed signature changes the checksum.
// - once the lock cell is set, array readback returns nothing useful.
// - the lock cell is cleared only by reset or by the erase step of a reprogramming cycle.
// - each programming cycle erases the configuration by itself first.
// - preload forces each registered output high or low, any state allowed.
// - during preload feedback is broken; normal clocking then proceeds from the forced state.
// - at power-up all register Q values go low within one microsecond.
// - after power-up reset enabled registered output pins read high whatever the polarity.
// - unused inputs read as logical one through the pull-ups.
module pldsup_top #(
    parameter int NREG  = `PLDSUP_NREG,
    parameter int CFG_W = `PLDSUP_CFG_BITS,
    parameter int SIG_W = `PLDSUP_SIG_BITS
) (
    input  wire logic             clk,
    input  wire logic             reset,
    // programmer side
    input  wire logic             prog_start,
    input  wire logic [CFG_W-1:0] prog_cfg,
    input  wire logic [SIG_W-1:0] prog_sig,
    input  wire logic             prog_lock,
    input  wire logic             rd_array_req,
    input  wire logic             rd_sig_req,
    output logic      [CFG_W-1:0] rd_data,
    output logic                  rd_valid,
    output logic                  rd_refused,
    output logic      [15:0]      csum_out,
    output logic                  lock_out,
    output logic                  prog_busy,
    // system side
    input  wire logic [NREG-1:0]  next_state,
    input  wire logic [NREG-1:0]  pin_in,
    input  wire logic [NREG-1:0]  pin_used,
    input  wire logic [NREG-1:0]  polarity,
    input  wire logic             preload_en,
    input  wire logic [NREG-1:0]  preload_val,
    output logic      [NREG-1:0]  q_out,
    output logic      [NREG-1:0]  pin_out,
    output logic      [NREG-1:0]  pin_level,
    output logic                  por_done
);
    localparam int TPR_CYC = `PLDSUP_TPR_CYC;
    localparam int PCW     = $clog2(TPR_CYC + 1);

    // ==========================================
    // pin synchronisers
    logic [NREG-1:0] pin_s1_r;
    logic [NREG-1:0] pin_s2_r;
    logic [NREG-1:0] pin_eff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // floating pins pull up
    assign pin_eff = pin_s2_r | ~pin_used;

    // ==========================================
    // configuration store
    pldsup_pkg::pldsup_prog_t st_r, st_nxt;
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic [SIG_W-1:0] sig_r, sig_nxt;
    logic             lock_r, lock_nxt;
    logic [CFG_W-1:0] rdd_r, rdd_nxt;
    logic             rdv_r, rdv_nxt;
    logic             rdf_r, rdf_nxt;
    logic [15:0]      csum_c;
    logic [15:0]      csum_r;

    always_comb begin
        st_nxt   = st_r;
        cfg_nxt  = cfg_r;
        sig_nxt  = sig_r;
        lock_nxt = lock_r;
        rdd_nxt  = '0;
        rdv_nxt  = 1'b0;
        rdf_nxt  = 1'b0;
        unique case (st_r)
            pldsup_pkg::PLDSUP_IDLE: begin
                if (prog_start) begin
                    st_nxt = pldsup_pkg::PLDSUP_ERASE;
                end else if (rd_sig_req) begin
                    rdd_nxt = CFG_W'(sig_r);
                    rdv_nxt = 1'b1;
                end else if (rd_array_req) begin
                    if (lock_r) begin
                        rdf_nxt = 1'b1;
                    end else begin
                        rdd_nxt = cfg_r;
                        rdv_nxt = 1'b1;
                    end
                end
            end
            pldsup_pkg::PLDSUP_ERASE: begin
                cfg_nxt  = '0;
                sig_nxt  = '0;
                lock_nxt = 1'b0;
                st_nxt   = pldsup_pkg::PLDSUP_WRITE;
            end
            pldsup_pkg::PLDSUP_WRITE: begin
                cfg_nxt  = prog_cfg;
                sig_nxt  = prog_sig;
                lock_nxt = prog_lock;
                st_nxt   = pldsup_pkg::PLDSUP_IDLE;
            end
            default: st_nxt = pldsup_pkg::PLDSUP_IDLE;
        endcase
    end

    pldsup_csum #(
        .CFG_W (CFG_W),
        .SIG_W (SIG_W)
    ) u_csum (
        .cfg  (cfg_r),
        .sig  (sig_r),
        .csum (csum_c)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r   <= pldsup_pkg::PLDSUP_IDLE;
            cfg_r  <= '0;
            sig_r  <= `PLDSUP_SIG_RESET;
            lock_r <= 1'b0;
            rdd_r  <= '0;
            rdv_r  <= 1'b0;
            rdf_r  <= 1'b0;
            csum_r <= `PLDSUP_CSUM_SEED;
        end else begin
            st_r   <= st_nxt;
            cfg_r  <= cfg_nxt;
            sig_r  <= sig_nxt;
            lock_r <= lock_nxt;
            rdd_r  <= rdd_nxt;
            rdv_r  <= rdv_nxt;
            rdf_r  <= rdf_nxt;
            csum_r <= csum_c;
        end
    end

    assign rd_data    = rdd_r;
    assign rd_valid   = rdv_r;
    assign rd_refused = rdf_r;
    assign csum_out   = csum_r;
    assign lock_out   = lock_r;

    // ==========================================
    // power-up reset and output registers
    logic [PCW-1:0]  por_cnt_r, por_cnt_nxt;
    logic            por_r, por_nxt;
    logic [NREG-1:0] q_r, q_nxt;
    logic [NREG-1:0] pin_r, pin_nxt;
    logic [NREG-1:0] lvl_r, lvl_nxt;
    logic            busy_r, busy_nxt;

    always_comb begin
        por_cnt_nxt = por_cnt_r;
        por_nxt     = por_r;
        q_nxt       = q_r;
        if (!por_r) begin
            // registers held low until reset window ends
            q_nxt = `PLDSUP_Q_RESET;
            if (por_cnt_r == PCW'(TPR_CYC - 1)) begin
                por_nxt = 1'b1;
            end else begin
                por_cnt_nxt = por_cnt_r + PCW'(1);
            end
        end else if (preload_en) begin
            // feedback ignored so the forced state holds
            q_nxt = preload_val;
        end else begin
            q_nxt = next_state;
        end
        // pin is inverted Q; polarity is not applied to it anywhere
        pin_nxt = ~q_nxt;
        lvl_nxt = pin_eff;
        busy_nxt    = (st_nxt != pldsup_pkg::PLDSUP_IDLE);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            por_cnt_r <= '0;
            por_r     <= 1'b0;
            q_r       <= `PLDSUP_Q_RESET;
            pin_r     <= '1;
            lvl_r     <= '1;
            busy_r    <= 1'b0;
        end else begin
            por_cnt_r <= por_cnt_nxt;
            por_r     <= por_nxt;
            q_r       <= q_nxt;
            pin_r     <= pin_nxt;
            lvl_r     <= lvl_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // polarity input is unused; the register pin stays ~Q
    assign q_out     = q_r;
    assign pin_out   = pin_r;
    assign pin_level = lvl_r;
    assign por_done  = por_r;
    assign prog_busy = busy_r;

    // ==========================================
    // checks
    AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (reset)
        (st_r == pldsup_pkg::PLDSUP_IDLE && !prog_start && !rd_sig_req && rd_array_req && lock_r)
        |=> (rd_refused && !rd_valid)) else $error("locked array read not refused");
    AST_SIG_READ: assert property (@(posedge clk) disable iff (reset)
        (st_r == pldsup_pkg::PLDSUP_IDLE && !prog_start && rd_sig_req)
        |=> (rd_valid && rd_data[SIG_W-1:0] == $past(sig_r))) else $error("signature read failed");
    AST_PROG_SEQ: assert property (@(posedge clk) disable iff (reset)
        (st_r == pldsup_pkg::PLDSUP_IDLE && prog_start)
        |=> (st_r == pldsup_pkg::PLDSUP_ERASE) ##1 (cfg_r == '0 && !lock_r)) else $error("no erase");
    AST_LOCK_CLEAR: assert property (@(posedge clk) disable iff (reset)
        ($fell(lock_r)) |-> ($past(st_r) == pldsup_pkg::PLDSUP_ERASE)) else $error("lock cleared");
    AST_PROG_SIG: assert property (@(posedge clk) disable iff (reset)
        (st_r == pldsup_pkg::PLDSUP_WRITE) |=> (sig_r == $past(prog_sig))) else $error("sig not stored");
    AST_CSUM_SIG: assert property (@(posedge clk) disable iff (reset)
        ($changed(sig_r) && $stable(cfg_r)) |=> $changed(csum_r)) else $error("checksum misses sig");
    AST_PRELOAD: assert property (@(posedge clk) disable iff (reset)
        (por_r && preload_en) |=> (q_r == $past(preload_val))) else $error("preload not applied");
    AST_POR_LOW: assert property (@(posedge clk) disable iff (reset)
        (!por_r) |=> (q_r == '0 && pin_out == '1)) else $error("power-up state wrong");
    AST_POR_TIME: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> ##[0:20] por_r) else $error("power-up too long");
    AST_PULLUP: assert property (@(posedge clk) disable iff (reset)
        (pin_used != '1) |=> ((pin_level | $past(pin_used)) == '1)) else $error("unused pin not high");
endmodule : pldsup_top

// >>> shared/pldsup_pkg.sv
package pldsup_pkg;
    typedef enum logic [1:0] {
        PLDSUP_IDLE,
        PLDSUP_ERASE,
        PLDSUP_WRITE
    } pldsup_prog_t;
endpackage : pldsup_pkg

// >>> shared/pldsup_regs.svh
`ifndef PLDSUP_REGS_SVH
`define PLDSUP_REGS_SVH
// ==========================================
// sizes and reset values
`define PLDSUP_SIG_BITS      64
`define PLDSUP_NREG          8
`define PLDSUP_CFG_BITS      64
`define PLDSUP_Q_RESET       8'h00
`define PLDSUP_SIG_RESET     64'h0000_0000_0000_0000
// ==========================================
// timing: power-up reset time in ns, 20 MHz clock
`define PLDSUP_TPR_NS        1000
`define PLDSUP_CLK_NS        50
`define PLDSUP_TPR_CYC       (`PLDSUP_TPR_NS / `PLDSUP_CLK_NS)
// ==========================================
// checksum seed, arbitrary
`define PLDSUP_CSUM_SEED     16'h0000
`endif

// >>> verification/pld_power_up_and_test_support_tb.sv
`timescale 1ns/100ps
`include "pldsup_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD at %0t got %h exp %h", $time, (a), (b)); end end
module pld_power_up_and_test_support_tb;
    logic        clk = 1'b0, reset = 1'b1, go = 1'b0, lk = 1'b0, rd_sig_req = 1'b0, rd_array_req = 1'b0;
    logic        preload_en = 1'b1, prog_start, prog_lock, rd_valid, rd_refused, lock_out, prog_busy, por_done, v, r;
    logic [63:0] cfg = 64'h0, sg = 64'h0, prog_cfg, prog_sig, rd_data, d;
    logic [7:0]  next_state = 8'h00, pin_in = 8'h00, pin_used = 8'hFF, polarity = 8'h0F, preload_val = 8'hFF;
    logic [7:0]  q_out, pin_out, pin_level;
    logic [15:0] csum_out, c1;
    int          n_mismatch = 0, samples_checked = 0, n;
    logic        clk_run = 1'b1;
    // rows: preload value, next state, pin input, pin used
    logic [31:0] rows [4] = '{32'hA53C_0F0F, 32'h5AC3_F00F, 32'hFF00_AA00, 32'h00FF_55FF};

    pldsup_prog_model prog (.clk, .reset, .go, .cfg_in(cfg), .sig_in(sg), .lock_in(lk),
                            .prog_start, .prog_cfg, .prog_sig, .prog_lock);
    pldsup_top dut (.clk, .reset, .prog_start, .prog_cfg, .prog_sig, .prog_lock, .rd_array_req, .rd_sig_req,
                    .rd_data, .rd_valid, .rd_refused, .csum_out, .lock_out, .prog_busy, .next_state, .pin_in,
                    .pin_used, .polarity, .preload_en, .preload_val, .q_out, .pin_out, .pin_level, .por_done);

    // parked low while clk_run is off, as the system must do during power-up
    always #25 clk = clk_run ? ~clk : 1'b0;

    // ==========================================
    // helpers
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // inputs always move 1 ns after the edge, well clear of set-up
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task prog_cycle(input logic [63:0] c, input logic [63:0] s, input logic l);
        logic seen;
        seen = 1'b0;
        cfg = c;
        sg = s;
        lk = l;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            if (prog_busy === 1'b1) seen = 1'b1;
        end
        `CHK(seen, 1'b1)
        `CHK(prog_busy, 1'b0)
    endtask : prog_cycle

    task rd(input logic s);
        rd_sig_req = s;
        rd_array_req = ~s;
        v = 1'b0;
        r = 1'b0;
        for (int i = 0; i < 3; i++) begin
            tick(1);
            rd_sig_req = 1'b0;
            rd_array_req = 1'b0;
            if (rd_valid === 1'b1 || rd_refused === 1'b1) begin
                v = rd_valid;
                r = rd_refused;
                d = rd_data;
                break;
            end
        end
    endtask : rd

    // ==========================================
    // main sequence
    initial begin
        tick(10);
        `CHK(q_out, 8'h00)
        `CHK(pin_out, 8'hFF)
        `CHK(pin_level, 8'hFF)
        reset = 1'b0;
        n = 0;
        // preload held on through the window must be ignored
        while (por_done !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        `CHK(n, `PLDSUP_TPR_CYC)
        `CHK(q_out, 8'h00)
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            {preload_val, next_state, pin_in, pin_used} = rows[i];
            preload_en = 1'b1;
            tick(2);
            `CHK(q_out, rows[i][31:24])
            `CHK(pin_out, ~rows[i][31:24])
            preload_en = 1'b0;
            tick(1);
            `CHK(q_out, rows[i][23:16])
            tick(3);
            `CHK(pin_level, rows[i][15:8] | ~rows[i][7:0])
        end
        $display("test preload rows done");
        prog_cycle(64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210, 1'b0);
        rd(1'b1);
        `CHK({v, d}, {1'b1, 64'hFEDC_BA98_7654_3210})
        rd(1'b0);
        `CHK({v, r, d}, {2'b10, 64'h0123_4567_89AB_CDEF})
        c1 = csum_out;
        prog_cycle(64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3211, 1'b1);
        `CHK(csum_out != c1, 1'b1)
        `CHK(lock_out, 1'b1)
        rd(1'b0);
        `CHK({v, r}, 2'b01)
        rd(1'b1);
        `CHK({v, d}, {1'b1, 64'hFEDC_BA98_7654_3211})
        prog_cycle(64'hAAAA_5555_AAAA_5555, 64'hFEDC_BA98_7654_3211, 1'b0);
        `CHK(lock_out, 1'b0)
        rd(1'b0);
        `CHK({v, r, d}, {2'b10, 64'hAAAA_5555_AAAA_5555})
        // array rewritten from the previous pattern to blank while the signature changes too
        c1 = csum_out;
        prog_cycle(64'h0000_0000_0000_0000, 64'h0000_0000_0000_0001, 1'b0);
        `CHK(csum_out != c1, 1'b1)
        rd(1'b1);
        `CHK({v, d}, {1'b1, 64'h0000_0000_0000_0001})
        $display("test programming done");
        // second power-up: clock parked, other polarity, q high from the last row
        polarity = 8'hF0;
        clk_run = 1'b0;
        reset = 1'b1;
        #(`PLDSUP_CLK_NS * 4);
        `CHK(q_out, 8'h00)
        `CHK(pin_out, 8'hFF)
        `CHK(por_done, 1'b0)
        clk_run = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(`PLDSUP_TPR_CYC - 1);
        `CHK(por_done, 1'b0)
        `CHK(q_out, 8'h00)
        tick(1);
        `CHK(por_done, 1'b1)
        $display("test second reset done");
        tally_and_finish();
    end

    initial begin
        #(`PLDSUP_CLK_NS * 2000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : pld_power_up_and_test_support_tb

// >>> verification/pldsup_prog_model.sv
`timescale 1ns/100ps
// ==========================================
// programmer model: one start per request, no erase command of its own
module pldsup_prog_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        go,
    input  wire logic [63:0] cfg_in,
    input  wire logic [63:0] sig_in,
    input  wire logic        lock_in,
    output logic             prog_start,
    output logic      [63:0] prog_cfg,
    output logic      [63:0] prog_sig,
    output logic             prog_lock
);
    logic [2:0] hold_r;
    // data only valid while the device samples it; inverted after so stale values never match
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_start <= 1'b0;
            prog_cfg   <= 64'h0;
            prog_sig   <= 64'h0;
            prog_lock  <= 1'b0;
            hold_r     <= 3'h0;
        end else if (go) begin
            prog_start <= 1'b1;
            prog_cfg   <= cfg_in;
            prog_sig   <= sig_in;
            prog_lock  <= lock_in;
            hold_r     <= 3'h5;
        end else begin
            prog_start <= 1'b0;
            if (hold_r != 3'h0) begin
                hold_r <= hold_r - 3'h1;
            end
            if (hold_r == 3'h1) begin
                prog_cfg  <= ~prog_cfg;
                prog_sig  <= ~prog_sig;
                prog_lock <= ~prog_lock;
            end
        end
    end
endmodule : pldsup_prog_model
